/* File: pud_ctrl.sv */
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - active profile is the binary value of the three select pins
// - profile words decode as single-tone when memory enable 0, playback when 1
// - serial writes stay staged; update strobe rising edge copies them to working
// - any change on the profile pins copies staged data like an update
// - internal-update bit makes updates internal and turns strobe pin to output
// - each internal update drives a high pulse of about 12 clocks on the pin
// - two-bit rate field divides half core clock by 1, 2, 4 or 8
// - 32-bit rate word sets the internal counter range
// - after reset rate field is 0 and rate word is 0xffff
// - rate word of 3 or less holds the strobe pin steadily high
// - four software power-down bits: core, main, auxiliary converter, clock input
// - core power-down blocks serial writes except one clearing that bit
// - with the pin low, sections follow their software power-down bits
// - with the pin high, core and both converters power down regardless of bits, clock input too unless fast recovery
// - control bit picks full or fast-recovery pin power-down keeping bias and clock
//////////////////////////////////////////////////////////////////////////////
module pud_ctrl (
    input  logic                         ref_clk,
    input  logic                         rst,
    input  logic                         clkEn,
    input  logic [pud_pkg::SEL_W-1:0]    profileSel,
    input  logic                         updIn,
    input  logic                         extPowerdownPin,
    input  logic                         wrEn,
    input  logic [pud_pkg::WSEL_W-1:0]   wrSel,
    input  logic [pud_pkg::PROF_W-1:0]   wrData,
    output logic                         updOut,
    output logic                         updOe,
    output logic [pud_pkg::SEL_W-1:0]    activeProfile,
    output logic                         ramMode,
    output pud_pkg::pud_tone_t           toneOut,
    output pud_pkg::pud_ram_t            ramOut,
    output pud_pkg::pud_pd_t             pdOut
);
    //////////////////////////////////////////////////////////////////////////
    // staged and working control
    pud_pkg::pud_ctrl1_t  stageC1, workC1, next_stageC1, next_workC1;
    pud_pkg::pud_ctrl2_t  stageC2, workC2, next_stageC2, next_workC2;
    logic [31:0]          stageRate, workRate, next_stageRate, next_workRate;
    logic [63:0]          rdData;
    logic                 memWr;
    logic                 wrOk;

    function automatic pud_pkg::pud_tone_t decode_tone(input logic [63:0] w);
        decode_tone.ftw = w[pud_pkg::TN_FTW_LO +: 32];
        decode_tone.pow = w[pud_pkg::TN_POW_LO +: 16];
        decode_tone.asf = w[pud_pkg::TN_ASF_LO +: 14];
    endfunction : decode_tone

    function automatic pud_pkg::pud_ram_t decode_ram(input logic [63:0] w);
        decode_ram.mode      = w[pud_pkg::RM_MODE_LO +: 3];
        decode_ram.startAddr = w[pud_pkg::RM_STA_LO +: 10];
        decode_ram.endAddr   = w[pud_pkg::RM_END_LO +: 10];
        decode_ram.rate      = w[pud_pkg::RM_RATE_LO +: 16];
    endfunction : decode_ram

    // a powered-down core takes only the write that wakes it
    assign wrOk  = wrEn && (!pdOut.digital ||
                   (wrSel == pud_pkg::SEL_CTRL1 && !wrData[pud_pkg::C1_PD_DIG]));
    assign memWr = wrOk && !wrSel[3];

    pud_prof_mem uMem (
        .ref_clk (ref_clk),
        .clkEn   (clkEn),
        .wrEn    (memWr),
        .wrAddr  (wrSel[2:0]),
        .wrData  (wrData),
        .rdAddr  (profileSel),
        .rdData  (rdData)
    );

    //////////////////////////////////////////////////////////////////////////
    // update events
    pud_pkg::pud_upd_t     updState, next_updState;
    logic [2:0]            prevSel, loadSel, next_prevSel, next_loadSel;
    logic                  updInPrev, next_updInPrev;
    logic                  extEdge, profChange, intUpd, updReq;

    assign extEdge    = !workC2.intUpdate && updIn && !updInPrev;
    assign profChange = profileSel != prevSel;
    assign updReq     = extEdge || profChange || intUpd;

    always_comb begin
        next_prevSel   = profileSel;
        next_updInPrev = updIn;
        next_loadSel   = loadSel;
        next_updState  = pud_pkg::UPD_IDLE;
        if (updReq) begin
            // memory read of the new selection lands one clock later
            next_updState = pud_pkg::UPD_LOAD;
            next_loadSel  = profileSel;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            updState  <= pud_pkg::UPD_IDLE;
            prevSel   <= 3'h0;
            loadSel   <= 3'h0;
            updInPrev <= 1'b0;
        end else if (clkEn) begin
            updState  <= next_updState;
            prevSel   <= next_prevSel;
            loadSel   <= next_loadSel;
            updInPrev <= next_updInPrev;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // staging and transfer to working hardware
    always_comb begin
        next_stageC1   = stageC1;
        next_stageC2   = stageC2;
        next_stageRate = stageRate;
        next_workC1    = workC1;
        next_workC2    = workC2;
        next_workRate  = workRate;
        if (wrOk) begin
            case (wrSel)
                pud_pkg::SEL_CTRL1: next_stageC1 = pud_pkg::pud_ctrl1_t'(wrData[5:0]);
                pud_pkg::SEL_CTRL2: next_stageC2 = pud_pkg::pud_ctrl2_t'(wrData[2:0]);
                pud_pkg::SEL_RATE:  next_stageRate = wrData[31:0];
                default:            next_stageRate = stageRate;
            endcase
        end
        if (updState == pud_pkg::UPD_LOAD) begin
            next_workC1   = stageC1;
            next_workC2   = stageC2;
            next_workRate = stageRate;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stageC1   <= '0;
            workC1    <= '0;
            stageC2   <= '{rateCtrl: pud_pkg::RATE_CTRL_RST, intUpdate: 1'b0};
            workC2    <= '{rateCtrl: pud_pkg::RATE_CTRL_RST, intUpdate: 1'b0};
            stageRate <= pud_pkg::RATE_WORD_RST;
            workRate  <= pud_pkg::RATE_WORD_RST;
        end else if (clkEn) begin
            stageC1   <= next_stageC1;
            workC1    <= next_workC1;
            stageC2   <= next_stageC2;
            workC2    <= next_workC2;
            stageRate <= next_stageRate;
            workRate  <= next_workRate;
        end
    end

    // working profile outputs
    pud_pkg::pud_tone_t  next_toneOut;
    pud_pkg::pud_ram_t   next_ramOut;
    logic [2:0]          next_activeProfile;
    logic                next_ramMode;

    always_comb begin
        next_toneOut       = toneOut;
        next_ramOut        = ramOut;
        next_activeProfile = activeProfile;
        next_ramMode       = ramMode;
        if (updState == pud_pkg::UPD_LOAD) begin
            next_activeProfile = loadSel;
            next_ramMode       = stageC1.ramEnable;
            if (stageC1.ramEnable) begin
                next_ramOut = decode_ram(rdData);
            end else begin
                next_toneOut = decode_tone(rdData);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            toneOut       <= '0;
            ramOut        <= '0;
            activeProfile <= 3'h0;
            ramMode       <= 1'b0;
        end else if (clkEn) begin
            toneOut       <= next_toneOut;
            ramOut        <= next_ramOut;
            activeProfile <= next_activeProfile;
            ramMode       <= next_ramMode;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // internal update generator
    logic [3:0]   presc, next_presc;
    logic [31:0]  updCnt, next_updCnt;
    logic [3:0]   pulseCnt, next_pulseCnt;
    logic         next_updOut, next_updOe;
    logic         tick, lowRate, hitNow;
    logic [3:0]   prescTop;
    logic [32:0]  cntSum;

    // half-rate clock then divide by 2^A, one tick per divided period
    assign prescTop = 4'((5'h2 << workC2.rateCtrl) - 5'h1);
    assign tick     = workC2.intUpdate && presc == prescTop;
    assign lowRate  = workRate <= pud_pkg::RATE_STATIC;
    // step of two per tick keeps the period near 2^A times the rate word
    assign cntSum   = {1'b0, updCnt} + pud_pkg::CNT_STEP;
    assign hitNow   = tick && cntSum >= {1'b0, workRate};
    assign intUpd   = hitNow;

    always_comb begin
        next_presc    = presc;
        next_updCnt   = updCnt;
        next_pulseCnt = pulseCnt;
        next_updOe    = workC2.intUpdate;
        next_updOut   = 1'b0;
        if (!workC2.intUpdate) begin
            next_presc    = 4'h0;
            next_updCnt   = 32'h0;
            next_pulseCnt = 4'h0;
        end else begin
            next_presc = tick ? 4'h0 : presc + 4'h1;
            if (tick) begin
                next_updCnt = hitNow ? 32'h0 : cntSum[31:0];
            end
            if (hitNow) begin
                next_pulseCnt = pud_pkg::PULSE_CYC;
            end else if (pulseCnt != 4'h0) begin
                next_pulseCnt = pulseCnt - 4'h1;
            end
            next_updOut = lowRate || next_pulseCnt != 4'h0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presc    <= 4'h0;
            updCnt   <= 32'h0;
            pulseCnt <= 4'h0;
            updOut   <= 1'b0;
            updOe    <= 1'b0;
        end else if (clkEn) begin
            presc    <= next_presc;
            updCnt   <= next_updCnt;
            pulseCnt <= next_pulseCnt;
            updOut   <= next_updOut;
            updOe    <= next_updOe;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // power-down
    pud_pkg::pud_pd_t next_pdOut;

    always_comb begin
        if (extPowerdownPin) begin
            next_pdOut = '{digital: 1'b1, dac: 1'b1, aux: 1'b1, refclk: 1'b1,
                           dacBias: 1'b1, pll: 1'b1};
            if (workC1.extFast) begin
                // fast wake keeps bias and clocking alive at a power cost
                next_pdOut.refclk  = 1'b0;
                next_pdOut.dacBias = 1'b0;
                next_pdOut.pll     = 1'b0;
            end
        end else begin
            next_pdOut = '{digital: workC1.pdDigital, dac: workC1.pdDac,
                           aux: workC1.pdAux, refclk: workC1.pdRefclk,
                           dacBias: workC1.pdDac, pll: workC1.pdRefclk};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pdOut <= '0;
        end else if (clkEn) begin
            pdOut <= next_pdOut;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    prof_change_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && profileSel != prevSel) |=> updState == pud_pkg::UPD_LOAD)
        else $error("profile change did not start a transfer");

    strobe_edge_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && !workC2.intUpdate && updIn && !updInPrev) |=> updState == pud_pkg::UPD_LOAD)
        else $error("strobe edge did not start a transfer");

    active_prof_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && updState == pud_pkg::UPD_LOAD) |=> activeProfile == $past(loadSel))
        else $error("active profile not taken from select pins");

    ext_pd_all_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && extPowerdownPin) |=> pdOut.digital && pdOut.dac && pdOut.aux)
        else $error("pin power-down missed a section");

    soft_pd_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && !extPowerdownPin) |=> pdOut.aux == $past(workC1.pdAux))
        else $error("software power-down bit not followed");

    fast_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && extPowerdownPin && workC1.extFast) |=> !pdOut.pll && !pdOut.dacBias)
        else $error("fast recovery powered down kept sections");

    blocked_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && wrEn && pdOut.digital && wrSel == pud_pkg::SEL_RATE) |=> $stable(stageRate))
        else $error("write accepted while core powered down");

    static_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && workC2.intUpdate && lowRate) |=> updOut)
        else $error("strobe not held high at low rate word");

    pulse_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && hitNow && !lowRate) ##1 clkEn[*2] |-> updOut && pulseCnt == 4'hb)
        else $error("internal update pulse length wrong");

    rate_reset_a: assert property (@(posedge ref_clk)
        $fell(rst) |-> workRate == pud_pkg::RATE_WORD_RST && workC2.rateCtrl == 2'h0)
        else $error("rate values wrong after reset");

    output_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && $changed(workC2.intUpdate)) |=> updOe == $past(workC2.intUpdate))
        else $error("strobe pin direction not following mode");

endmodule : pud_ctrl

/* File: pud_ctrl_tb.sv */
`timescale 1ns/100ps
module pud_ctrl_tb;
    typedef struct packed {
        logic [2:0]  prof;
        logic [63:0] word;
    } pud_row_t;

    logic               ref_clk;
    logic               rst;
    logic               clkEn;
    logic               wrEn;
    logic [3:0]         wrSel;
    logic [63:0]        wrData;
    logic               hostStrobe;
    logic               extPowerdownPin;
    logic [2:0]         profileSel;
    logic               updOut;
    logic               updOe;
    logic [2:0]         activeProfile;
    logic               ramMode;
    pud_pkg::pud_tone_t toneOut;
    pud_pkg::pud_ram_t  ramOut;
    pud_pkg::pud_pd_t   pdOut;
    wire                updIn = updOe ? updOut : hostStrobe;
    int                 failures;
    int                 comparisons;
    int                 n;
    logic [63:0]        lastWord;
    pud_row_t           rows [8];

    pud_ctrl i_pud_ctrl (
        .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .profileSel(profileSel),
        .updIn(updIn), .extPowerdownPin(extPowerdownPin), .wrEn(wrEn),
        .wrSel(wrSel), .wrData(wrData), .updOut(updOut), .updOe(updOe),
        .activeProfile(activeProfile), .ramMode(ramMode), .toneOut(toneOut),
        .ramOut(ramOut), .pdOut(pdOut)
    );

    pud_host_model i_pud_host_model (
        .ref_clk(ref_clk), .pinOe(updOe), .profileSel(profileSel),
        .strobeDrv(hostStrobe), .extPowerdownPin(extPowerdownPin)
    );

    //////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        failures++;
        test_done();
    end

    //////////////////////////////////////////////////////////////////////////////
    function automatic pud_pkg::pud_tone_t toneOf(input logic [63:0] w);
        return {w[pud_pkg::TN_ASF_LO+:14], w[pud_pkg::TN_POW_LO+:16], w[pud_pkg::TN_FTW_LO+:32]};
    endfunction : toneOf

    function automatic pud_pkg::pud_ram_t ramOf(input logic [63:0] w);
        return {w[pud_pkg::RM_RATE_LO+:16], w[pud_pkg::RM_END_LO+:10],
                w[pud_pkg::RM_STA_LO+:10], w[pud_pkg::RM_MODE_LO+:3]};
    endfunction : ramOf

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask : tick

    task automatic wrWord(input logic [3:0] sel, input logic [63:0] d);
        @(posedge ref_clk) #2;
        wrEn = 1'b1;
        wrSel = sel;
        wrData = d;
        @(posedge ref_clk) #2;
        wrEn = 1'b0;
    endtask : wrWord

    task automatic xfer(input int hold);
        i_pud_host_model.pulseStrobe(hold);
        tick(2);
    endtask : xfer

    // first waits out any high phase, so the count ends on a fresh rise
    task automatic waitRise(input int maxCyc, output int k);
        k = 0;
        while (updOut === 1'b1 && k < maxCyc) begin
            tick(1);
            k++;
        end
        while (updOut !== 1'b1 && k < maxCyc) begin
            tick(1);
            k++;
        end
    endtask : waitRise

    task automatic chkVal(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkVal

    task automatic chkCnt(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chkCnt

    task automatic test_done();
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    //////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        wrEn = 1'b0;
        wrSel = 4'h0;
        wrData = 64'h0;
        rows = '{'{3'h5, 64'h0123_4567_89ab_cdef}, '{3'h0, 64'h3fff_ffff_ffff_ffff},
                 '{3'h7, 64'h0000_0000_0000_0001}, '{3'h1, 64'h2aaa_5555_aaaa_5555},
                 '{3'h6, 64'h1555_aaaa_5555_aaaa}, '{3'h2, 64'h0fed_cba9_8765_4321},
                 '{3'h4, 64'h3000_8000_8000_0000}, '{3'h3, 64'h0102_0304_0506_0708}};
        tick(12);
        rst = 1'b0;
        tick(1);
        chkVal(64'({pdOut, updOe, updOut, activeProfile}), 64'h0);
        foreach (rows[i]) begin
            wrWord(4'(rows[i].prof), rows[i].word);
            i_pud_host_model.setProfile(rows[i].prof);
            tick(4);
            chkVal(64'(activeProfile), 64'(rows[i].prof));
            chkVal(64'(toneOut), 64'(toneOf(rows[i].word)));
            chkVal(64'(ramMode), 64'h0);
        end
        // frozen clock enable: a profile change waits until it returns
        clkEn = 1'b0;
        i_pud_host_model.setProfile(3'h1);
        tick(4);
        chkVal(64'(activeProfile), 64'h3);
        clkEn = 1'b1;
        tick(3);
        chkVal(64'(activeProfile), 64'h1);
        chkVal(64'(toneOut), 64'(toneOf(rows[3].word)));
        i_pud_host_model.setProfile(3'h3);
        tick(4);
        // staged write must not show until the strobe edge
        lastWord = 64'h1234_0000_5678_9abc;
        wrWord(4'h3, lastWord);
        tick(6);
        chkVal(64'(toneOut), 64'(toneOf(rows[7].word)));
        xfer(6);
        chkVal(64'(toneOut), 64'(toneOf(lastWord)));
        wrWord(pud_pkg::SEL_CTRL1, 64'h01);
        wrWord(4'h3, lastWord);
        xfer(2);
        chkVal(64'({ramMode, ramOut}), 64'({1'b1, ramOf(lastWord)}));
        // power-down sections from bits, pin override, fast recovery
        wrWord(pud_pkg::SEL_CTRL1, 64'h04);
        xfer(2);
        chkVal(64'(pdOut), 64'h12);
        chkVal(64'(toneOut), 64'(toneOf(lastWord)));
        wrWord(pud_pkg::SEL_CTRL1, 64'h18);
        xfer(2);
        chkVal(64'(pdOut), 64'h0d);
        i_pud_host_model.setPowerdown(1'b1);
        tick(3);
        chkVal(64'(pdOut), 64'h3f);
        i_pud_host_model.setPowerdown(1'b0);
        wrWord(pud_pkg::SEL_CTRL1, 64'h24);
        xfer(2);
        i_pud_host_model.setPowerdown(1'b1);
        tick(3);
        chkVal(64'(pdOut), 64'h38);
        i_pud_host_model.setPowerdown(1'b0);
        tick(3);
        chkVal(64'(pdOut), 64'h12);
        // core down: only a write clearing its own bit gets through
        wrWord(pud_pkg::SEL_CTRL1, 64'h02);
        xfer(2);
        chkVal(64'(pdOut), 64'h20);
        wrWord(4'h3, 64'h0);
        wrWord(pud_pkg::SEL_RATE, 64'h0);
        wrWord(pud_pkg::SEL_CTRL1, 64'h06);
        xfer(2);
        chkVal(64'(pdOut), 64'h20);
        chkVal(64'(toneOut), 64'(toneOf(lastWord)));
        wrWord(pud_pkg::SEL_CTRL1, 64'h00);
        xfer(2);
        chkVal(64'(pdOut), 64'h00);
        // internal updates: every rate code, period and pulse width
        wrWord(pud_pkg::SEL_RATE, 64'h10);
        wrWord(pud_pkg::SEL_CTRL2, 64'h01);
        xfer(2);
        chkVal(64'(updOe), 64'h1);
        for (int a = 0; a < 4; a++) begin
            wrWord(pud_pkg::SEL_CTRL2, 64'((a << 1) | 1));
            waitRise(400, n);
            waitRise(400, n);
            waitRise(400, n);
            chkCnt(n, (16 << a) - 2, (16 << a) + 2);
            n = 0;
            while (updOut === 1'b1 && n < 40) begin
                tick(1);
                n++;
            end
            chkCnt(n, 12, 12);
        end
        wrWord(pud_pkg::SEL_RATE, 64'h03);
        tick(300);
        n = 0;
        for (int k = 0; k < 60; k++) begin
            n += (updOut === 1'b1) ? 1 : 0;
            tick(1);
        end
        chkCnt(n, 60, 60);
        wrWord(pud_pkg::SEL_CTRL2, 64'h00);
        // mode change only lands at the next internal update, up to 32 clocks away
        tick(40);
        chkVal(64'(updOe), 64'h0);
        // second reset, then default rate word sets the period
        rst = 1'b1;
        tick(3);
        chkVal(64'({pdOut, updOe, updOut, activeProfile}), 64'h0);
        rst = 1'b0;
        tick(4);
        wrWord(pud_pkg::SEL_CTRL2, 64'h01);
        xfer(2);
        waitRise(70000, n);
        chkCnt(n, 65500, 65560);
        test_done();
    end
endmodule : pud_ctrl_tb

/* File: pud_host_model.sv */
`timescale 1ns/100ps
module pud_host_model (
    input  logic       ref_clk,
    input  logic       pinOe,
    output logic [2:0] profileSel,
    output logic       strobeDrv,
    output logic       extPowerdownPin
);
    localparam int DRV_DLY = 2;

    initial begin
        profileSel      = 3'h0;
        strobeDrv       = 1'b0;
        extPowerdownPin = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////////
    // plain binary index on the select pins
    task automatic setProfile(input logic [2:0] p);
        @(posedge ref_clk) #DRV_DLY;
        profileSel = p;
    endtask : setProfile

    // larger hold mimics a slow host; low time after lets the edge be seen again
    task automatic pulseStrobe(input int hold);
        @(posedge ref_clk) #DRV_DLY;
        strobeDrv = !pinOe;
        repeat (hold) @(posedge ref_clk);
        #DRV_DLY;
        strobeDrv = 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : pulseStrobe

    task automatic setPowerdown(input logic v);
        @(posedge ref_clk) #DRV_DLY;
        extPowerdownPin = v;
    endtask : setPowerdown
endmodule : pud_host_model

/* File: pud_pkg.sv */
package pud_pkg;

    localparam int unsigned PROF_W     = 64;
    localparam int unsigned PROF_N     = 8;
    localparam int unsigned SEL_W      = 3;
    localparam int unsigned WSEL_W     = 4;

    // write-port targets; 0..7 address the profile words
    localparam logic [3:0] SEL_CTRL1   = 4'h8;
    localparam logic [3:0] SEL_CTRL2   = 4'h9;
    localparam logic [3:0] SEL_RATE    = 4'ha;

    // control word one bit positions
    localparam int unsigned C1_RAM_EN  = 0;
    localparam int unsigned C1_PD_DIG  = 1;
    localparam int unsigned C1_PD_DAC  = 2;
    localparam int unsigned C1_PD_AUX  = 3;
    localparam int unsigned C1_PD_REF  = 4;
    localparam int unsigned C1_EXT_FST = 5;

    // control word two bit positions
    localparam int unsigned C2_INT_UPD = 0;
    localparam int unsigned C2_RATE_LO = 1;

    // single-tone profile fields
    localparam int unsigned TN_FTW_LO  = 0;
    localparam int unsigned TN_POW_LO  = 32;
    localparam int unsigned TN_ASF_LO  = 48;
    // memory-playback profile fields
    localparam int unsigned RM_MODE_LO = 0;
    localparam int unsigned RM_STA_LO  = 14;
    localparam int unsigned RM_END_LO  = 30;
    localparam int unsigned RM_RATE_LO = 40;

    localparam logic [1:0]  RATE_CTRL_RST = 2'h0;
    localparam logic [31:0] RATE_WORD_RST = 32'h0000ffff;
    localparam logic [31:0] RATE_STATIC   = 32'h00000003;
    localparam logic [32:0] CNT_STEP      = 33'h000000002;

    localparam real         CORE_CLK_NS   = 50.0;
    localparam real         PULSE_CORE_CYC = 12.0;
    localparam logic [3:0]  PULSE_CYC     = 4'(int'(PULSE_CORE_CYC));

    typedef struct packed {
        logic extFast;
        logic pdRefclk;
        logic pdAux;
        logic pdDac;
        logic pdDigital;
        logic ramEnable;
    } pud_ctrl1_t;

    typedef struct packed {
        logic [1:0] rateCtrl;
        logic       intUpdate;
    } pud_ctrl2_t;

    typedef struct packed {
        logic [13:0] asf;
        logic [15:0] pow;
        logic [31:0] ftw;
    } pud_tone_t;

    typedef struct packed {
        logic [15:0] rate;
        logic [9:0]  endAddr;
        logic [9:0]  startAddr;
        logic [2:0]  mode;
    } pud_ram_t;

    typedef struct packed {
        logic digital;
        logic dac;
        logic aux;
        logic refclk;
        logic dacBias;
        logic pll;
    } pud_pd_t;

    typedef enum logic {UPD_IDLE, UPD_LOAD} pud_upd_t;

endpackage : pud_pkg

/* File: pud_prof_mem.sv */
`timescale 1ns/100ps
module pud_prof_mem (
    input  logic                        ref_clk,
    input  logic                        clkEn,
    input  logic                        wrEn,
    input  logic [pud_pkg::SEL_W-1:0]   wrAddr,
    input  logic [pud_pkg::PROF_W-1:0]  wrData,
    input  logic [pud_pkg::SEL_W-1:0]   rdAddr,
    output logic [pud_pkg::PROF_W-1:0]  rdData
);
    // staged profile words; no reset, contents are software's to define
    logic [pud_pkg::PROF_W-1:0] mem [pud_pkg::PROF_N];

    always_ff @(posedge ref_clk) begin
        if (clkEn) begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end
endmodule : pud_prof_mem
